// >>> gia_pkg.sv
/*
 * constants, field positions and carrier types for the global interrupt
 * aggregator; assumes a 32-bit AHB-Lite register bus and 16 switch ports.
 */
`default_nettype none

package gia_pkg;

	// ------------------------------------------------------------------
	// register byte addresses
	// ------------------------------------------------------------------
	localparam logic [31:0] GIA_OFS_FLAGS = 32'h0001_AC00;
	localparam logic [31:0] GIA_OFS_GATE = 32'h0001_AC04;
	localparam logic [31:0] GIA_OFS_EVENT = 32'h0001_AC08;
	localparam logic [31:0] GIA_OFS_EVMASK = 32'h0001_AC0C;

	// ------------------------------------------------------------------
	// field positions (same layout in every register)
	// ------------------------------------------------------------------
	localparam int unsigned GIA_NUM_PORTS = 16;
	localparam int unsigned GIA_BIT_RST_SYM = 4;
	localparam int unsigned GIA_BIT_MCAST_SYM = 5;
	localparam int unsigned GIA_BIT_MGMT_BUS = 6;
	localparam int unsigned GIA_BIT_FABRIC_ERR = 7;
	localparam int unsigned GIA_BIT_LAT_EXP = 14;
	localparam int unsigned GIA_BIT_PORT_LO = 16;
	localparam int unsigned GIA_BIT_PORT_HI = 31;
	localparam logic [31:0] GIA_DEFINED_MASK = 32'hFFFF_40F0;

	// ------------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------------
	localparam logic [31:0] GIA_GATE_RST = 32'h0000_0000;
	localparam logic [31:0] GIA_EVENT_RST = 32'h0000_0000;
	localparam logic [31:0] GIA_EVMASK_RST = 32'h0000_0000;
	localparam logic [31:0] GIA_RDATA_RST = 32'h0000_0000;
	localparam logic GIA_INT_N_RST = 1'b1;

	// ------------------------------------------------------------------
	// bus encodings
	// ------------------------------------------------------------------
	localparam logic [1:0] GIA_HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] GIA_HTRANS_SEQ = 2'h3;
	localparam logic GIA_HRESP_OKAY = 1'b0;

	// ------------------------------------------------------------------
	// carriers; vectors are indexed by port number
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [15:0] reset_symbol_req;
		logic [15:0] mcast_event_req;
		logic mgmt_bus_req;
		logic fabric_transfer_error;
		logic [15:0] latency_expiry_req;
		logic [15:0] port_lt_err;
		logic [15:0] port_err_stat;
		logic [15:0] port_int_stat;
	} gia_src_s;

	typedef struct packed {
		logic valid;
		logic write;
		logic [31:0] addr;
	} gia_cmd_s;

endpackage : gia_pkg

`default_nettype wire

// >>> gia_flag_merge.sv
/*
 * merges the raw requests of every source into the flags word;
 * assumes requests come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module gia_flag_merge (
	input wire gia_pkg::gia_src_s i_src,
	output logic [31:0] o_flags
);

	logic [31:0] flags;

	// ------------------------------------------------------------------
	// per-port bits, port 15 lowest
	// ------------------------------------------------------------------
	genvar p;
	generate
		for (p = 0; p < gia_pkg::GIA_NUM_PORTS; p++) begin : g_port
			// any of the three port causes raises the port bit
			assign flags[gia_pkg::GIA_BIT_PORT_HI - p] = i_src.port_lt_err[p] |
				i_src.port_err_stat[p] | i_src.port_int_stat[p];
		end
	endgenerate

	// ------------------------------------------------------------------
	// global sources, reserved bits tied low
	// ------------------------------------------------------------------
	assign flags[3:0] = 4'h0;
	assign flags[gia_pkg::GIA_BIT_RST_SYM] = |i_src.reset_symbol_req;
	assign flags[gia_pkg::GIA_BIT_MCAST_SYM] = |i_src.mcast_event_req;
	assign flags[gia_pkg::GIA_BIT_MGMT_BUS] = i_src.mgmt_bus_req;
	assign flags[gia_pkg::GIA_BIT_FABRIC_ERR] = i_src.fabric_transfer_error;
	assign flags[13:8] = 6'h00;
	assign flags[gia_pkg::GIA_BIT_LAT_EXP] = |i_src.latency_expiry_req;
	assign flags[15] = 1'b0;

	assign o_flags = flags;

endmodule : gia_flag_merge

`default_nettype wire

// >>> gia_ahb_front.sv
/*
 * AHB-Lite address-phase capture: presents the live address phase and
 * the registered data-phase command; assumes a single master.
 */
`timescale 1ns/1ps
`default_nettype none

module gia_ahb_front (
	input wire logic i_ref_clk,
	input wire logic i_arst_n,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic i_hready,
	output var gia_pkg::gia_cmd_s o_addr_ph,
	output var gia_pkg::gia_cmd_s o_data_ph
);

	gia_pkg::gia_cmd_s addr_ph;
	gia_pkg::gia_cmd_s nxt_data_ph;
	gia_pkg::gia_cmd_s data_ph_ff;

	// ------------------------------------------------------------------
	// address phase decode
	// ------------------------------------------------------------------
	always_comb begin
		addr_ph.valid = i_hsel & i_hready &
			((i_htrans == gia_pkg::GIA_HTRANS_NONSEQ) | (i_htrans == gia_pkg::GIA_HTRANS_SEQ));
		addr_ph.write = i_hwrite;
		addr_ph.addr = {i_haddr[31:2], 2'h0}; // word aligned
	end

	// data phase follows one accepted address phase
	always_comb begin
		nxt_data_ph = data_ph_ff;
		if (i_hready) begin
			nxt_data_ph = addr_ph;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			data_ph_ff <= '0;
		end else begin
			data_ph_ff <= nxt_data_ph;
		end
	end

	assign o_addr_ph = addr_ph;
	assign o_data_ph = data_ph_ff;

endmodule : gia_ahb_front

`default_nettype wire

// >>> gia_top.sv
/*
 * global interrupt aggregator: flags, gate and event registers on
 * AHB-Lite, active-low host interrupt pin and masked event interrupt.
 * assumes source requests are synchronous to i_ref_clk.
 */
// Design decision made here: the AHB-Lite register port.
// Functional notes
// - a source reaches the host pin only when its gate bit is set.
// - flags bit 14 is one while any broadcast buffer latency has expired.
// - flags bits 16 to 31 show ports 15 down to 0, read only, reset zero.
// - a port bit joins its transport error, error status and interrupt causes.
// - gate bits 4 to 7 are read-write, reset zero, for the four global sources.
// - gate bit 14 is a read-write latency gate that resets to zero.
// - gate bits 16 to 31 are read-write port gates, bit 16 for port 15.
// - each flag is the plain OR of its source requests, never latched.
// - an interrupt is raised whenever a flag and its gate are both set.
// - flags bits 4 and 5 combine the reset and multicast symbol requests.
`timescale 1ns/1ps
`default_nettype none

module gia_top (
	input wire logic i_ref_clk,
	input wire logic i_arst_n,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic o_hreadyout,
	output logic o_hresp,
	output logic [31:0] o_hrdata,
	input wire gia_pkg::gia_src_s i_src,
	output logic o_int_n,
	output logic o_evt_irq
);

	gia_pkg::gia_cmd_s addr_ph;
	gia_pkg::gia_cmd_s data_ph;
	logic [31:0] flags;
	logic [31:0] gate_ff;
	logic [31:0] nxt_gate_ff;
	logic [31:0] event_ff;
	logic [31:0] nxt_event_ff;
	logic [31:0] evmask_ff;
	logic [31:0] nxt_evmask_ff;
	logic [31:0] flags_prev_ff;
	logic [31:0] hrdata_ff;
	logic [31:0] nxt_hrdata_ff;
	logic int_n_ff;
	logic nxt_int_n_ff;
	logic evt_irq_ff;
	logic nxt_evt_irq_ff;
	logic wr_en;
	logic [31:0] wr_bits;
	logic [31:0] rise;

	// ------------------------------------------------------------------
	// leaf blocks
	// ------------------------------------------------------------------
	gia_flag_merge u_merge (
		.i_src(i_src),
		.o_flags(flags)
	);

	gia_ahb_front u_front (
		.i_ref_clk(i_ref_clk),
		.i_arst_n(i_arst_n),
		.i_hsel(i_hsel),
		.i_haddr(i_haddr),
		.i_htrans(i_htrans),
		.i_hwrite(i_hwrite),
		.i_hready(i_hready),
		.o_addr_ph(addr_ph),
		.o_data_ph(data_ph)
	);

	// ------------------------------------------------------------------
	// register writes in the data phase
	// ------------------------------------------------------------------
	// only defined bit positions can be written
	assign wr_en = data_ph.valid & data_ph.write;
	assign wr_bits = i_hwdata & gia_pkg::GIA_DEFINED_MASK;
	assign rise = flags & ~flags_prev_ff;

	// gate, event and event mask next values
	always_comb begin
		nxt_gate_ff = gate_ff;
		nxt_evmask_ff = evmask_ff;
		nxt_event_ff = event_ff;
		if (wr_en && (data_ph.addr == gia_pkg::GIA_OFS_GATE)) begin
			nxt_gate_ff = wr_bits;
		end
		if (wr_en && (data_ph.addr == gia_pkg::GIA_OFS_EVMASK)) begin
			nxt_evmask_ff = wr_bits;
		end
		if (wr_en && (data_ph.addr == gia_pkg::GIA_OFS_EVENT)) begin
			nxt_event_ff = event_ff & ~wr_bits; // write one to clear
		end
		nxt_event_ff = nxt_event_ff | rise; // new edge beats the clear
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			gate_ff <= gia_pkg::GIA_GATE_RST;
			evmask_ff <= gia_pkg::GIA_EVMASK_RST;
			event_ff <= gia_pkg::GIA_EVENT_RST;
			flags_prev_ff <= gia_pkg::GIA_EVENT_RST;
		end else begin
			gate_ff <= nxt_gate_ff;
			evmask_ff <= nxt_evmask_ff;
			event_ff <= nxt_event_ff;
			flags_prev_ff <= flags;
		end
	end

	// ------------------------------------------------------------------
	// read data, captured in the address phase
	// ------------------------------------------------------------------
	// forwards a write still in its data phase; unmapped reads give zero
	always_comb begin
		nxt_hrdata_ff = hrdata_ff;
		if (addr_ph.valid && !addr_ph.write) begin
			case (addr_ph.addr)
				gia_pkg::GIA_OFS_FLAGS: nxt_hrdata_ff = flags;
				gia_pkg::GIA_OFS_GATE: nxt_hrdata_ff = nxt_gate_ff;
				gia_pkg::GIA_OFS_EVENT: nxt_hrdata_ff = nxt_event_ff;
				gia_pkg::GIA_OFS_EVMASK: nxt_hrdata_ff = nxt_evmask_ff;
				default: nxt_hrdata_ff = gia_pkg::GIA_RDATA_RST;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// interrupt outputs
	// ------------------------------------------------------------------
	// host pin from gated live flags, event line from masked sticky bits
	always_comb begin
		nxt_int_n_ff = ~|(flags & gate_ff);
		nxt_evt_irq_ff = |(event_ff & evmask_ff);
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			hrdata_ff <= gia_pkg::GIA_RDATA_RST;
			int_n_ff <= gia_pkg::GIA_INT_N_RST;
			evt_irq_ff <= 1'b0;
		end else begin
			hrdata_ff <= nxt_hrdata_ff;
			int_n_ff <= nxt_int_n_ff;
			evt_irq_ff <= nxt_evt_irq_ff;
		end
	end

	// zero wait states, always OKAY
	assign o_hreadyout = 1'b1;
	assign o_hresp = gia_pkg::GIA_HRESP_OKAY;
	assign o_hrdata = hrdata_ff;
	assign o_int_n = int_n_ff;
	assign o_evt_irq = evt_irq_ff;

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_arst_n);

	sequence s_gate_write;
		data_ph.valid && data_ph.write && (data_ph.addr == gia_pkg::GIA_OFS_GATE);
	endsequence

	sequence s_flags_read;
		addr_ph.valid && !addr_ph.write && (addr_ph.addr == gia_pkg::GIA_OFS_FLAGS);
	endsequence

	a_pin_needs_gate: assert property ((~|(flags & gate_ff)) |=> o_int_n)
		else $error("host pin low with no gated source");

	a_lat_flag_live: assert property (flags[14] == (|i_src.latency_expiry_req))
		else $error("latency expiry flag does not match buffers");

	a_port_order: assert property (flags[16] == (i_src.port_int_stat[15] |
		i_src.port_lt_err[15] | i_src.port_err_stat[15]) && flags[31] == (i_src.port_int_stat[0] |
		i_src.port_lt_err[0] | i_src.port_err_stat[0]))
		else $error("port flag order wrong");

	a_port_cause_or: assert property (i_src.port_err_stat[2] |-> flags[29])
		else $error("port error status not shown");

	a_gate_global: assert property (s_gate_write |=> gate_ff[7:4] == $past(i_hwdata[7:4]))
		else $error("global gate bits not written");

	a_gate_latency: assert property (s_gate_write |=> gate_ff[14] == $past(i_hwdata[14]))
		else $error("latency gate bit not written");

	a_gate_ports: assert property (s_gate_write |=> gate_ff[31:16] == $past(i_hwdata[31:16]))
		else $error("port gate bits not written");

	a_flag_unlatched: assert property ($fell(i_src.mgmt_bus_req) |-> !flags[6])
		else $error("management flag latched");

	a_raise_int: assert property ((|(flags & gate_ff)) |=> !o_int_n)
		else $error("gated flag did not raise interrupt");

	a_symbol_flags: assert property (flags[4] == (|i_src.reset_symbol_req) &&
		flags[5] == (|i_src.mcast_event_req))
		else $error("symbol flags do not combine all ports");

	a_reserved_zero: assert property (((gate_ff | flags) & ~gia_pkg::GIA_DEFINED_MASK) == 32'h0)
		else $error("reserved bit set");

	a_read_flags: assert property (s_flags_read |=> o_hrdata == $past(flags))
		else $error("flags read returned wrong value");

	a_event_sticky: assert property (event_ff[16] && !(wr_en &&
		(data_ph.addr == gia_pkg::GIA_OFS_EVENT) && i_hwdata[16]) |=> event_ff[16])
		else $error("event bit lost without clear");

	// ------------------------------------------------------------------
	// register bus and event checks
	// ------------------------------------------------------------------
	// gate read with no gate write in its data phase
	sequence s_gate_read_quiet;
		addr_ph.valid && !addr_ph.write && (addr_ph.addr == gia_pkg::GIA_OFS_GATE) &&
			!(wr_en && (data_ph.addr == gia_pkg::GIA_OFS_GATE));
	endsequence

	// event mask read with no mask write in its data phase
	sequence s_mask_read_quiet;
		addr_ph.valid && !addr_ph.write && (addr_ph.addr == gia_pkg::GIA_OFS_EVMASK) &&
			!(wr_en && (data_ph.addr == gia_pkg::GIA_OFS_EVMASK));
	endsequence

	// read of an address with no register behind it
	sequence s_other_read;
		addr_ph.valid && !addr_ph.write && (addr_ph.addr != gia_pkg::GIA_OFS_FLAGS) &&
			(addr_ph.addr != gia_pkg::GIA_OFS_GATE) &&
			(addr_ph.addr != gia_pkg::GIA_OFS_EVENT) &&
			(addr_ph.addr != gia_pkg::GIA_OFS_EVMASK);
	endsequence

	// one written to event bit 31 while that flag is not rising
	sequence s_event_clear;
		wr_en && (data_ph.addr == gia_pkg::GIA_OFS_EVENT) && i_hwdata[31] && !rise[31];
	endsequence

	// cycle with no gate write in its data phase
	sequence s_gate_quiet;
		!(wr_en && (data_ph.addr == gia_pkg::GIA_OFS_GATE));
	endsequence

	a_gate_readback: assert property (s_gate_read_quiet |=>
		o_hrdata == $past(gate_ff))
		else $error("gate read returned wrong value");

	a_mask_readback: assert property (s_mask_read_quiet |=>
		o_hrdata == $past(evmask_ff))
		else $error("event mask read returned wrong value");

	a_unmapped_zero: assert property (s_other_read |=>
		o_hrdata == 32'h0000_0000)
		else $error("unmapped read not zero");

	a_rdata_hold: assert property (!(addr_ph.valid && !addr_ph.write) |=>
		$stable(o_hrdata))
		else $error("read data changed with no read");

	a_gate_hold: assert property (s_gate_quiet |=> $stable(gate_ff))
		else $error("gate changed without a write");

	a_mask_hold: assert property (!(wr_en && (data_ph.addr == gia_pkg::GIA_OFS_EVMASK)) |=>
		$stable(evmask_ff))
		else $error("event mask changed without a write");

	a_bus_okay: assert property (o_hreadyout && (o_hresp == gia_pkg::GIA_HRESP_OKAY))
		else $error("bus stalled or not okay");

	a_mask_reserved: assert property (
		(evmask_ff & ~gia_pkg::GIA_DEFINED_MASK) == 32'h0000_0000)
		else $error("reserved event mask bit set");

	a_global_flags: assert property (flags[6] == i_src.mgmt_bus_req &&
		flags[7] == i_src.fabric_transfer_error)
		else $error("management or fabric flag wrong");

	a_port_lt_err: assert property (i_src.port_lt_err[1] |-> flags[30])
		else $error("port transport error not shown");

	a_lat_ungated: assert property ((flags == 32'h0000_4000) && !gate_ff[14] |=>
		o_int_n)
		else $error("ungated latency flag reached the pin");

	a_irq_flag_b_gated: assert property (flags[31] && gate_ff[31] |=> !o_int_n)
		else $error("gated port 0 flag did not reach the pin");

	a_event_rise: assert property ($rose(flags[31]) |=> event_ff[31])
		else $error("flag rise did not set event bit");

	a_event_clear: assert property (s_event_clear |=> !event_ff[31])
		else $error("event bit not cleared by write");

	a_evt_line_on: assert property ((|(event_ff & evmask_ff)) |=> o_evt_irq)
		else $error("event line low with masked event set");

	a_evt_line_off: assert property (!(|(event_ff & evmask_ff)) |=> !o_evt_irq)
		else $error("event line high with no masked event");

endmodule : gia_top

`default_nettype wire

// >>> gia_host_model.sv
/*
 * host model watching the active-low interrupt pin of the aggregator;
 * assumes the pin is a level synchronous to i_ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module gia_host_model (
	input wire logic i_ref_clk,
	input wire logic i_arst_n,
	input wire logic i_int_n,
	output logic [7:0] o_irq_cnt
);
	// ------------------------------------------------------------------
	// assertion counter
	// ------------------------------------------------------------------
	logic int_d_ff;

	// counts each fall of the pin, as a host would take an interrupt
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			int_d_ff <= 1'b1;
			o_irq_cnt <= 8'h00;
		end else begin
			int_d_ff <= i_int_n;
			if (int_d_ff && !i_int_n) begin
				o_irq_cnt <= o_irq_cnt + 8'h01;
			end
		end
	end
endmodule : gia_host_model

`default_nettype wire

// >>> tb_top.sv
/*
 * self-checking bench for the global interrupt aggregator;
 * assumes gia_pkg, gia_top and gia_host_model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	// ------------------------------------------------------------------
	// signals and instances
	// ------------------------------------------------------------------
	logic ref_clk = 1'b0;
	logic arst_n, hsel, hwrite, hready, hreadyout, hresp, int_n, evt_irq;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [7:0] irq_cnt;
	gia_pkg::gia_src_s src;
	int err_count = 0;
	int compares = 0;

	always #10 ref_clk = ~ref_clk;
	assign hready = hreadyout;

	gia_top u_gia_top (.i_ref_clk(ref_clk), .i_arst_n(arst_n), .i_hsel(hsel),
		.i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
		.i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hreadyout),
		.o_hresp(hresp), .o_hrdata(hrdata), .i_src(src), .o_int_n(int_n),
		.o_evt_irq(evt_irq));
	gia_host_model u_gia_host_model (.i_ref_clk(ref_clk), .i_arst_n(arst_n),
		.i_int_n(int_n), .o_irq_cnt(irq_cnt));

	// ------------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------------
	task automatic complete_run;
		$display("compares %0d, mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : complete_run

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask : check

	// waits for an edge with hready high, bounded
	task automatic wait_rdy;
		int n;
		n = 0;
		@(posedge ref_clk);
		while (hready !== 1'b1) begin
			n++;
			if (n > 16) begin
				err_count++;
				$display("wrong value at %0t: bus hang", $time);
				complete_run;
			end
			@(posedge ref_clk);
		end
	endtask : wait_rdy

	// one single word transfer, address phase then data phase
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		@(posedge ref_clk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= gia_pkg::GIA_HTRANS_NONSEQ;
		hwrite <= wr;
		wait_rdy;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy;
		rd = hrdata;
		check({31'h0, hresp}, {31'h0, gia_pkg::GIA_HRESP_OKAY}, "response");
	endtask : bus

	task automatic put_src(input gia_pkg::gia_src_s s);
		@(posedge ref_clk);
		src <= s;
	endtask : put_src

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : cyc

	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task automatic t_regs;
		bus(1'b0, gia_pkg::GIA_OFS_GATE, 32'h0);
		check(rd, 32'h0000_0000, "gate reset");
		bus(1'b0, gia_pkg::GIA_OFS_FLAGS, 32'h0);
		check(rd, 32'h0000_0000, "flags reset");
		check({31'h0, int_n}, 32'h1, "pin idle");
		bus(1'b1, gia_pkg::GIA_OFS_GATE, 32'hFFFF_FFFF);
		bus(1'b0, gia_pkg::GIA_OFS_GATE, 32'h0);
		check(rd, 32'hFFFF_40F0, "gate readback");
		bus(1'b1, gia_pkg::GIA_OFS_GATE, 32'h0000_0000);
		bus(1'b0, gia_pkg::GIA_OFS_GATE, 32'h0);
		check(rd, 32'h0000_0000, "gate cleared");
		bus(1'b1, gia_pkg::GIA_OFS_FLAGS, 32'hFFFF_FFFF);
		bus(1'b0, gia_pkg::GIA_OFS_FLAGS, 32'h0);
		check(rd, 32'h0000_0000, "flags read only");
		bus(1'b0, 32'h0001_AC20, 32'h0);
		check(rd, 32'h0000_0000, "unmapped read");
		$display("test regs done");
	endtask : t_regs

	// each port and each cause lands on bit 31 - port
	task automatic t_ports;
		gia_pkg::gia_src_s s;
		for (int p = 0; p < 16; p++) begin
			s = '0;
			case (p % 3)
				0: s.port_int_stat[p] = 1'b1;
				1: s.port_lt_err[p] = 1'b1;
				default: s.port_err_stat[p] = 1'b1;
			endcase
			put_src(s);
			bus(1'b0, gia_pkg::GIA_OFS_FLAGS, 32'h0);
			check(rd, 32'h1 << (31 - p), "port flag");
		end
		put_src('0);
		bus(1'b0, gia_pkg::GIA_OFS_FLAGS, 32'h0);
		check(rd, 32'h0, "flags follow sources");
		$display("test ports done");
	endtask : t_ports

	task automatic t_global;
		gia_pkg::gia_src_s s;
		logic [31:0] e;
		for (int k = 0; k < 5; k++) begin
			s = '0;
			case (k)
				0: begin s.reset_symbol_req[15] = 1'b1; e = 32'h0000_0010; end
				1: begin s.mcast_event_req[0] = 1'b1; e = 32'h0000_0020; end
				2: begin s.mgmt_bus_req = 1'b1; e = 32'h0000_0040; end
				3: begin s.fabric_transfer_error = 1'b1; e = 32'h0000_0080; end
				default: begin s.latency_expiry_req[7] = 1'b1; e = 32'h0000_4000; end
			endcase
			put_src(s);
			bus(1'b0, gia_pkg::GIA_OFS_FLAGS, 32'h0);
			check(rd, e, "global flag");
		end
		put_src('0);
		$display("test global done");
	endtask : t_global

	task automatic t_gating;
		gia_pkg::gia_src_s s;
		logic [7:0] n0;
		s = '0;
		s.port_int_stat[0] = 1'b1;
		n0 = irq_cnt;
		bus(1'b1, gia_pkg::GIA_OFS_GATE, 32'h0000_4000);
		put_src(s);
		cyc(3);
		check({31'h0, int_n}, 32'h1, "ungated source");
		bus(1'b1, gia_pkg::GIA_OFS_GATE, 32'h8000_0000);
		cyc(2);
		check({31'h0, int_n}, 32'h0, "gated source");
		check({24'h0, irq_cnt}, {24'h0, n0 + 8'h01}, "host saw one");
		put_src('0);
		cyc(2);
		check({31'h0, int_n}, 32'h1, "source gone");
		bus(1'b1, gia_pkg::GIA_OFS_EVENT, 32'hFFFF_FFFF);
		bus(1'b1, gia_pkg::GIA_OFS_EVMASK, 32'h8000_0000);
		put_src(s);
		cyc(3);
		check({31'h0, evt_irq}, 32'h1, "event raised");
		bus(1'b1, gia_pkg::GIA_OFS_EVENT, 32'h8000_0000);
		cyc(2);
		check({31'h0, evt_irq}, 32'h0, "event cleared");
		put_src('0);
		$display("test gating done");
	endtask : t_gating

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		arst_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		src = '0;
		repeat (3) @(posedge ref_clk);
		arst_n <= 1'b1;
		t_regs;
		t_ports;
		t_global;
		t_gating;
		complete_run;
	end
endmodule : tb_top

`default_nettype wire
